// ### verification/pesf_term.sv
// Terminal model: Avalon-MM master that issues card commands
`timescale 1ns/100ps
module pesf_term (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i,
  output logic      [4:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o,
  output logic      [3:0]  byteenable_o
);
  initial begin
    address_o    = 5'h00;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = 32'h0;
    byteenable_o = 4'hf;
  end

  // ---------------------------------------------------------------
  // Bus cycle
  // ---------------------------------------------------------------
  // Request held until waitrequest low; released lines show garbage
  // No limit of its own: a hung slave is left to the bench watchdog
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      input logic [3:0] lanes = 4'hf);
    q = 32'h0;
    @(posedge core_clk_i);
    address_o    <= a;
    writedata_o  <= d;
    byteenable_o <= lanes;
    write_o      <= wr;
    read_o       <= !wr;
    do begin
      @(posedge core_clk_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o      <= 1'b0;
    write_o     <= 1'b0;
    address_o   <= ~a;
    writedata_o <= ~d;
  endtask

  // ---------------------------------------------------------------
  // Card command
  // ---------------------------------------------------------------
  // operands go out ahead of the command word
  // one command at a time, status read after completion
  task automatic card_cmd(input pesf_pkg::pesf_op_t op, input logic e,
                          input logic [31:0] pin, input logic [31:0] code,
                          input logic [31:0] npin, output logic [15:0] sw);
    logic [31:0] q;
    xfer(1'b1, pesf_pkg::OFS_PIN, pin, q);
    xfer(1'b1, pesf_pkg::OFS_UNBLK, code, q);
    xfer(1'b1, pesf_pkg::OFS_NEWPIN, npin, q);
    xfer(1'b1, pesf_pkg::OFS_CMD, {23'h0, e, 5'h00, op}, q);
    xfer(1'b0, pesf_pkg::OFS_RESULT, 32'h0, q);
    sw = q[15:0];
  endtask
endmodule // pesf_term

// ### verification/pesf_top_tb.sv
// Self-checking testbench of the PIN enable / unblock block
`timescale 1ns/100ps
module pesf_top_tb;
  localparam logic [31:0] PIN_OK  = 32'h3030_3030;
  localparam logic [31:0] CODE_OK = 32'h3131_3131;
  localparam logic [31:0] BAD     = 32'h3939_3939;
  localparam logic [31:0] NEWP    = 32'h3333_3333;

  logic        core_clk_i;
  logic        srst_i;
  logic        ce_i;
  logic [4:0]  address;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  int          n_mismatch;
  int          checks_done;

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  pesf_top #(.PIN_INIT(PIN_OK), .UNBLK_CODE(CODE_OK), .PIN_EN_INIT(1'b1))
  pesf_top_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .address_i(address), .read_i(rd), .write_i(wr), .writedata_i(wdata),
    .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(waitreq));

  pesf_term pesf_term_inst (
    .core_clk_i(core_clk_i), .readdata_i(rdata), .waitrequest_i(waitreq),
    .address_o(address), .read_o(rd), .write_o(wr), .writedata_o(wdata),
    .byteenable_o(be));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input pesf_pkg::pesf_op_t op, input logic [31:0] p,
                     input logic [15:0] exp, input logic e = 1'b0,
                     input logic [31:0] np = PIN_OK);
    logic [15:0] sw;
    pesf_term_inst.card_cmd(op, e, p, p, np, sw);
    chk({16'h0, sw}, {16'h0, exp});
  endtask

  // Card reset: new session, status word not judged
  task automatic session();
    logic [15:0] sw;
    pesf_term_inst.card_cmd(pesf_pkg::OP_SESSION, 1'b0, 0, 0, 0, sw);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] q;
    pesf_term_inst.xfer(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask

  task automatic tlv(input logic [7:0] v);
    cmd(pesf_pkg::OP_STATUS, 0, 16'h9000);
    rd_chk(pesf_pkg::OFS_TLV, 32'h00ff_ffff, {8'h00, 16'h9001, v});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_enable();
    cmd(pesf_pkg::OP_READ, 0, 16'h6982);
    cmd(pesf_pkg::OP_ENABLE, PIN_OK, 16'h6985);
    cmd(pesf_pkg::OP_DISABLE, PIN_OK, 16'h9000);
    cmd(pesf_pkg::OP_READ, 0, 16'h9000);
    cmd(pesf_pkg::OP_ENABLE, BAD, 16'h63c2);
    tlv(8'h00);
    cmd(pesf_pkg::OP_ENABLE, BAD, 16'h63c1);
    cmd(pesf_pkg::OP_ENABLE, PIN_OK, 16'h9000);
    tlv(8'h80);
    cmd(pesf_pkg::OP_VERIFY, 0, 16'h63c3, 1'b1);
    session();
    cmd(pesf_pkg::OP_READ, 0, 16'h6982);
  endtask

  task automatic s_block_disabled();
    cmd(pesf_pkg::OP_DISABLE, PIN_OK, 16'h9000);
    cmd(pesf_pkg::OP_ENABLE, BAD, 16'h63c2);
    cmd(pesf_pkg::OP_ENABLE, BAD, 16'h63c1);
    session();
    cmd(pesf_pkg::OP_ENABLE, BAD, 16'h63c0);
    cmd(pesf_pkg::OP_ENABLE, PIN_OK, 16'h6983);
    cmd(pesf_pkg::OP_READ, 0, 16'h9000);
    cmd(pesf_pkg::OP_UNBLOCK, CODE_OK, 16'h9000, 1'b0, NEWP);
    tlv(8'h80);
    cmd(pesf_pkg::OP_VERIFY, 0, 16'h63c3, 1'b1);
    cmd(pesf_pkg::OP_UNBLOCK, 0, 16'h63ca, 1'b1);
    cmd(pesf_pkg::OP_READ, 0, 16'h9000);
    cmd(pesf_pkg::OP_VERIFY, NEWP, 16'h9000);
  endtask

  task automatic s_block_enabled();
    cmd(pesf_pkg::OP_VERIFY, BAD, 16'h63c2);
    cmd(pesf_pkg::OP_VERIFY, BAD, 16'h63c1);
    cmd(pesf_pkg::OP_VERIFY, BAD, 16'h63c0);
    cmd(pesf_pkg::OP_READ, 0, 16'h6982);
    cmd(pesf_pkg::OP_VERIFY, NEWP, 16'h6983);
    cmd(pesf_pkg::OP_UNBLOCK, BAD, 16'h63c9);
    rd_chk(pesf_pkg::OFS_STATE, 32'h35, 32'h05);
    cmd(pesf_pkg::OP_READ, 0, 16'h6982);
    cmd(pesf_pkg::OP_UNBLOCK, CODE_OK, 16'h9000);
    cmd(pesf_pkg::OP_UNBLOCK, 0, 16'h63ca, 1'b1);
    cmd(pesf_pkg::OP_VERIFY, 0, 16'h63c3, 1'b1);
    cmd(pesf_pkg::OP_VERIFY, BAD, 16'h63c2);
    cmd(pesf_pkg::OP_UNBLOCK, CODE_OK, 16'h9000);
    cmd(pesf_pkg::OP_VERIFY, 0, 16'h63c3, 1'b1);
  endtask

  task automatic s_exhaust();
    logic [31:0] q;
    for (int i = 9; i >= 1; i--) begin
      cmd(pesf_pkg::OP_UNBLOCK, BAD, {12'h63c, 4'(i)});
    end
    session();
    cmd(pesf_pkg::OP_UNBLOCK, BAD, 16'h63c0);
    cmd(pesf_pkg::OP_UNBLOCK, CODE_OK, 16'h6983);
    cmd(pesf_pkg::OP_UNBLOCK, 0, 16'h63c0, 1'b1);
    cmd(pesf_pkg::OP_NONE, 0, pesf_pkg::SW_BAD_OP);
    pesf_term_inst.xfer(1'b1, pesf_pkg::OFS_RESULT, 32'h1234, q);
    rd_chk(pesf_pkg::OFS_RESULT, 32'hffff, {16'h0, pesf_pkg::SW_BAD_OP});
    rd_chk(5'h1c, 32'hffff_ffff, 32'h0);
    pesf_term_inst.xfer(1'b1, pesf_pkg::OFS_PIN, 32'h1122_3344, q, 4'h5);
    rd_chk(pesf_pkg::OFS_PIN, 32'hffff_ffff, 32'h0022_0044);
  endtask

  // Clock enable low: a read stays unanswered until ce_i returns
  task automatic s_freeze();
    logic [31:0] q;
    ce_i <= 1'b0;
    fork
      pesf_term_inst.xfer(1'b0, pesf_pkg::OFS_STATE, 32'h0, q);
      begin
        repeat (6) @(posedge core_clk_i);
        chk({31'h0, waitreq}, 32'h1);
        ce_i <= 1'b1;
      end
    join
    // Enabled, unverified, code blocked, PIN tries 3, code tries 0
    chk(q, 32'h0000_0039);
  endtask

  // ---------------------------------------------------------------
  // Verdict and run control
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run is well under 5000 cycles; margin for slow answers
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    srst_i      = 1'b1;
    ce_i        = 1'b1;
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    s_enable();
    s_block_disabled();
    s_block_enabled();
    s_exhaust();
    s_freeze();
    tally_and_finish();
  end
endmodule // pesf_top_tb

// ### verilog/pesf_pkg.sv
// Package: register map, command codes and status words of the PIN block
package pesf_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CMD    = 5'h00;
  localparam logic [4:0] OFS_PIN    = 5'h04;
  localparam logic [4:0] OFS_UNBLK  = 5'h08;
  localparam logic [4:0] OFS_NEWPIN = 5'h0c;
  localparam logic [4:0] OFS_RESULT = 5'h10;
  localparam logic [4:0] OFS_STATE  = 5'h14;
  localparam logic [4:0] OFS_TLV    = 5'h18;

  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_EMPTY_BIT = 8;

  typedef enum logic [2:0] {
    OP_VERIFY  = 3'h0,
    OP_ENABLE  = 3'h1,
    OP_DISABLE = 3'h2,
    OP_UNBLOCK = 3'h3,
    OP_READ    = 3'h4,
    OP_STATUS  = 3'h5,
    OP_SESSION = 3'h6,
    OP_NONE    = 3'h7
  } pesf_op_t;

  typedef struct packed {
    logic     empty;
    pesf_op_t op;
  } pesf_cmd_t;

  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
  } pesf_sw_t;

  // ---------------------------------------------------------------
  // Counter reset values and status words
  // ---------------------------------------------------------------
  localparam logic [1:0] PIN_TRIES_INIT   = 2'h3;
  localparam logic [3:0] UNBLK_TRIES_INIT = 4'ha;

  localparam pesf_sw_t SW_OK        = '{sw1: 8'h90, sw2: 8'h00};
  localparam pesf_sw_t SW_DENIED    = '{sw1: 8'h69, sw2: 8'h82};
  localparam pesf_sw_t SW_BLOCKED   = '{sw1: 8'h69, sw2: 8'h83};
  localparam pesf_sw_t SW_NOT_ALLOW = '{sw1: 8'h69, sw2: 8'h85};
  localparam pesf_sw_t SW_BAD_OP    = '{sw1: 8'h6d, sw2: 8'h00};
  localparam logic [7:0] SW1_RETRY  = 8'h63;
  localparam logic [7:0] SW2_RETRY  = 8'hc0;

  // Security status template entry of the STATUS answer
  localparam logic [7:0] TLV_TAG     = 8'h90;
  localparam logic [7:0] TLV_LEN     = 8'h01;
  localparam logic [7:0] TLV_ENABLED = 8'h80;
  localparam logic [7:0] TLV_DISABLE = 8'h00;

endpackage

// ### verilog/pesf_top.sv
// PIN enable / unblock security state machine with Avalon-MM slave
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Functional notes
// R1: Unblock restores PIN retry counter, then conditionally installs new PIN.
// R2: Unblock takes PIN target, unblock code and replacement PIN.
// R3: Unblock runs whether or not the PIN is blocked.
// R4: Correct unblock code stores new PIN, unblock tries 10, PIN tries 3.
// R5: Successful unblock enables PIN and satisfies access for session.
// R6: Wrong unblock code decrements the unblock retry counter.
// R7: Ten wrong unblock codes across sessions block the unblock code.
// R8: Wrong unblock code leaves PIN enable, block and counter untouched.
// R9: Unblock with empty data only reports remaining unblock retries, retry_count_status_word.
// R10: Any failed code check ends with an error status.
// R11: Wrong PIN on enable gives retry_count_status_word, decrements, PIN stays disabled.
// R12: Correct PIN on enable while disabled gives 9000 and enables.
// R13: After enable, empty verify reports 63C3.
// R14: Enabled, unverified PIN refuses protected read with 6982.
// R15: Third wrong PIN gives 63C0 across resets and blocks the PIN.
// R16: PIN-presenting command while blocked gives 6983.
// R17: Blocked and enabled PIN denies protected access with 6982.
// R18: Blocked but disabled PIN keeps granting access, 9000.
// R19: Enable while enabled or blocked is refused with an error.
// R20: STATUS answer carries tag 90 showing PIN enabled or disabled.
// R21: Three wrong PINs across sessions block; counter kept non-volatile.
// R22: One command at a time; counters updated before status is given.
// ---------------------------------------------------------------
module pesf_top #(
  parameter logic [31:0] PIN_INIT     = 32'h3030_3030,
  parameter logic [31:0] UNBLK_CODE   = 32'h3131_3131,
  parameter logic        PIN_EN_INIT  = 1'b1
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ACK  = 2'b10
  } pesf_state_t;

  pesf_state_t        st;
  pesf_pkg::pesf_cmd_t cmd;
  pesf_pkg::pesf_sw_t  result;
  logic [31:0]        pin_in;
  logic [31:0]        unblk_in;
  logic [31:0]        newpin_in;
  logic [31:0]        pin_ref;
  logic [1:0]         pin_tries;
  logic [3:0]         unblk_tries;
  logic               pin_enabled;
  logic               pin_verified;
  logic [23:0]        tlv;
  logic [31:0]        next_rdata;
  logic               exec;
  logic               pin_blocked;
  logic               unblk_blocked;
  logic               pin_match;
  logic               unblk_match;
  logic               access_ok;
  logic               bus_req;

  // Merge a write into a register by byte lanes
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Retry status word built from a remaining-attempts count
  function automatic pesf_pkg::pesf_sw_t retry_sw(input logic [3:0] n);
    pesf_pkg::pesf_sw_t s;
    s.sw1 = pesf_pkg::SW1_RETRY;
    s.sw2 = pesf_pkg::SW2_RETRY | {4'h0, n};
    return s;
  endfunction

  assign exec          = (st == ST_EXEC);
  assign bus_req       = (st == ST_IDLE) && (read_i || write_i);
  assign pin_blocked   = (pin_tries == 2'h0);
  assign unblk_blocked = (unblk_tries == 4'h0);
  assign pin_match     = (pin_in == pin_ref);
  assign unblk_match   = (unblk_in == UNBLK_CODE);
  // R17 blocked gate
  // A disabled PIN keeps access even when blocked
  assign access_ok     = !pin_enabled || (pin_verified && !pin_blocked);

  always_comb begin
    next_rdata = 32'h0;
    unique case (address_i)
      pesf_pkg::OFS_CMD:    next_rdata = {23'h0, cmd.empty, 5'h0, cmd.op};
      pesf_pkg::OFS_PIN:    next_rdata = pin_in;
      pesf_pkg::OFS_UNBLK:  next_rdata = unblk_in;
      pesf_pkg::OFS_NEWPIN: next_rdata = newpin_in;
      pesf_pkg::OFS_RESULT: next_rdata = {16'h0, result};
      pesf_pkg::OFS_STATE:  next_rdata = {20'h0, unblk_tries, 2'h0,
                                          pin_tries, unblk_blocked,
                                          pin_blocked, pin_verified,
                                          pin_enabled};
      pesf_pkg::OFS_TLV:    next_rdata = {8'h0, tlv};
      default:              next_rdata = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // R22 serial commands
  // Command writes hold waitrequest until all counters have settled
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st            <= ST_IDLE;
      waitrequest_o <= 1'b1;
      readdata_o    <= 32'h0;
      cmd           <= '{empty: 1'b0, op: pesf_pkg::OP_NONE};
    end else if (ce_i) begin
      unique case (st)
        ST_IDLE: begin
          if (write_i && address_i == pesf_pkg::OFS_CMD) begin
            cmd.op    <= pesf_pkg::pesf_op_t'(
                           writedata_i[pesf_pkg::CMD_OP_LSB +: 3]);
            cmd.empty <= writedata_i[pesf_pkg::CMD_EMPTY_BIT];
            st        <= ST_EXEC;
          end else if (read_i || write_i) begin
            if (read_i) begin
              readdata_o <= next_rdata;
            end
            waitrequest_o <= 1'b0;
            st            <= ST_ACK;
          end
        end
        ST_EXEC: begin
          waitrequest_o <= 1'b0;
          st            <= ST_ACK;
        end
        ST_ACK: begin
          waitrequest_o <= 1'b1;
          st            <= ST_IDLE;
        end
        default: begin
          waitrequest_o <= 1'b1;
          st            <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command operands
  // ---------------------------------------------------------------
  // R2 unblock inputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_in    <= 32'h0;
      unblk_in  <= 32'h0;
      newpin_in <= 32'h0;
    end else if (ce_i && bus_req && write_i) begin
      if (address_i == pesf_pkg::OFS_PIN) begin
        pin_in <= merge_be(pin_in, writedata_i, byteenable_i);
      end
      if (address_i == pesf_pkg::OFS_UNBLK) begin
        unblk_in <= merge_be(unblk_in, writedata_i, byteenable_i);
      end
      if (address_i == pesf_pkg::OFS_NEWPIN) begin
        newpin_in <= merge_be(newpin_in, writedata_i, byteenable_i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Security state
  // ---------------------------------------------------------------
  // Counters survive a session restart; apart from successful code checks, only srst_i reloads them,
  // standing in for the non-volatile store.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_ref      <= PIN_INIT;
      pin_tries    <= pesf_pkg::PIN_TRIES_INIT;
      unblk_tries  <= pesf_pkg::UNBLK_TRIES_INIT;
      pin_enabled  <= PIN_EN_INIT;
      pin_verified <= 1'b0;
      result       <= pesf_pkg::SW_OK;
      tlv          <= 24'h0;
    end else if (ce_i && exec) begin
      unique case (cmd.op)
        pesf_pkg::OP_VERIFY: begin
          if (cmd.empty) begin
            // R13 retry report
            result <= retry_sw({2'h0, pin_tries});
          end else if (pin_blocked) begin
            // R16 blocked refusal
            result <= pesf_pkg::SW_BLOCKED;
          end else if (pin_match) begin
            pin_tries    <= pesf_pkg::PIN_TRIES_INIT;
            pin_verified <= 1'b1;
            result       <= pesf_pkg::SW_OK;
          end else begin
            // R21 persistent count
            pin_tries    <= pin_tries - 2'h1;
            pin_verified <= 1'b0;
            // R10 error status
            result       <= retry_sw({2'h0, pin_tries - 2'h1});
          end
        end
        pesf_pkg::OP_ENABLE: begin
          if (pin_blocked) begin
            // R16 blocked refusal
            result <= pesf_pkg::SW_BLOCKED;
          end else if (pin_enabled) begin
            // R19 already enabled
            result <= pesf_pkg::SW_NOT_ALLOW;
          end else if (pin_match) begin
            // R12 enable PIN
            pin_tries   <= pesf_pkg::PIN_TRIES_INIT;
            pin_enabled <= 1'b1;
            result      <= pesf_pkg::SW_OK;
          end else begin
            // R11 wrong enable
            // R15 third failure
            pin_tries <= pin_tries - 2'h1;
            result    <= retry_sw({2'h0, pin_tries - 2'h1});
          end
        end
        pesf_pkg::OP_DISABLE: begin
          if (pin_blocked) begin
            result <= pesf_pkg::SW_BLOCKED;
          end else if (!pin_enabled) begin
            result <= pesf_pkg::SW_NOT_ALLOW;
          end else if (pin_match) begin
            pin_tries   <= pesf_pkg::PIN_TRIES_INIT;
            pin_enabled <= 1'b0;
            result      <= pesf_pkg::SW_OK;
          end else begin
            pin_tries <= pin_tries - 2'h1;
            result    <= retry_sw({2'h0, pin_tries - 2'h1});
          end
        end
        pesf_pkg::OP_UNBLOCK: begin
          // R3 regardless of block
          if (cmd.empty) begin
            // R9 report only
            result <= retry_sw(unblk_tries);
          end else if (unblk_blocked) begin
            // R7 code blocked
            result <= pesf_pkg::SW_BLOCKED;
          end else if (unblk_match) begin
            // R1 restore then install
            // R4 reload counters
            // R5 enable and satisfy
            pin_tries    <= pesf_pkg::PIN_TRIES_INIT;
            pin_ref      <= newpin_in;
            unblk_tries  <= pesf_pkg::UNBLK_TRIES_INIT;
            pin_enabled  <= 1'b1;
            pin_verified <= 1'b1;
            result       <= pesf_pkg::SW_OK;
          end else begin
            // R6 decrement code
            // R8 PIN untouched
            unblk_tries <= unblk_tries - 4'h1;
            result      <= retry_sw(unblk_tries - 4'h1);
          end
        end
        pesf_pkg::OP_READ: begin
          // R14 unverified refusal
          // R18 disabled grant
          result <= access_ok ? pesf_pkg::SW_OK : pesf_pkg::SW_DENIED;
        end
        pesf_pkg::OP_STATUS: begin
          // R20 template entry
          tlv    <= {pesf_pkg::TLV_TAG, pesf_pkg::TLV_LEN,
                     pin_enabled ? pesf_pkg::TLV_ENABLED
                                 : pesf_pkg::TLV_DISABLE};
          result <= pesf_pkg::SW_OK;
        end
        pesf_pkg::OP_SESSION: begin
          // Card reset: session rights lost, counters kept
          pin_verified <= 1'b0;
          result       <= pesf_pkg::SW_OK;
        end
        pesf_pkg::OP_NONE: begin
          result <= pesf_pkg::SW_BAD_OP;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  logic unb_ok;
  logic unb_bad;
  assign unb_ok  = exec && ce_i && cmd.op == pesf_pkg::OP_UNBLOCK &&
                   !cmd.empty && !unblk_blocked && unblk_match;
  assign unb_bad = exec && ce_i && cmd.op == pesf_pkg::OP_UNBLOCK &&
                   !cmd.empty && !unblk_blocked && !unblk_match;

  a_unblock_reload: assert property ( // R4
    unb_ok |=> pin_tries == 2'h3 && unblk_tries == 4'ha &&
               pin_ref == $past(newpin_in))
    else $error("unblock did not reload counters");

  a_unblock_enables: assert property ( // R5
    unb_ok |=> pin_enabled && pin_verified && result == pesf_pkg::SW_OK)
    else $error("unblock did not enable PIN");

  a_unblock_wrong: assert property ( // R6
    unb_bad |=> unblk_tries == $past(unblk_tries) - 4'h1 &&
                result.sw1 == 8'h63)
    else $error("wrong unblock code not counted");

  a_wrong_keeps_pin: assert property ( // R8
    unb_bad |=> $stable(pin_enabled) && $stable(pin_tries) &&
                $stable(pin_ref))
    else $error("wrong unblock code changed PIN state");

  a_empty_report: assert property ( // R9
    (exec && ce_i && cmd.op == pesf_pkg::OP_UNBLOCK && cmd.empty) |=>
      result == {8'h63, 4'hc, unblk_tries} && $stable(unblk_tries))
    else $error("empty unblock not a retry report");

  a_blocked_refuse: assert property ( // R16
    (exec && ce_i && pin_blocked && !cmd.empty &&
     (cmd.op == pesf_pkg::OP_VERIFY || cmd.op == pesf_pkg::OP_ENABLE))
      |=> result == pesf_pkg::SW_BLOCKED)
    else $error("blocked PIN not refused");

  a_access_gate: assert property ( // R17
    (exec && ce_i && cmd.op == pesf_pkg::OP_READ) |=>
      result == ($past(access_ok) ? pesf_pkg::SW_OK : pesf_pkg::SW_DENIED))
    else $error("protected read answer wrong");

  a_enable_refused: assert property ( // R19
    (exec && ce_i && cmd.op == pesf_pkg::OP_ENABLE && pin_enabled) |=>
      result != pesf_pkg::SW_OK && pin_enabled)
    else $error("enable of enabled PIN executed");

  a_tries_bounded: assert property ( // R21
    pin_tries <= 2'h3 && unblk_tries <= 4'ha)
    else $error("retry counter out of range");

  a_cmd_latency: assert property ( // R22
    (bus_req && ce_i && write_i && address_i == pesf_pkg::OFS_CMD) ##1 ce_i
      |-> waitrequest_o ##1 !waitrequest_o)
    else $error("command answer timing wrong");

  c_unblock_ok:   cover property (unb_ok);
  c_pin_blocks:   cover property ($fell(pin_tries != 2'h0));
  c_code_blocks:  cover property ($fell(unblk_tries != 4'h0));
  c_read_denied:  cover property (result == pesf_pkg::SW_DENIED);

endmodule // pesf_top
